//--- rtl/tcc_timer16.sv
// Compare-output control of one 16-bit timer instance with a minimal counter around it.
// Assumes an Avalon-MM master on core_clk and a one-cycle timer_tick from a prescaler.
// The second timer instance is a second copy of this module in its own bus slot.
// Pins carry the waveform only while their override enables are high; the port
// logic outside keeps the pad otherwise.
`timescale 1ns/10ps
`include "tcc_defines.svh"

// Register map, in byte offsets on the bus; data sits in the low bits of each word.
//   0x00  control A: output actions, force strobes and low mode bits.
//   0x04  upper mode bits, waveform_mode_select[3:2] in bits 1:0.
//   0x08  count_value, readable and writable at any time.
//   0x0C  compare A buffer; reads return the buffer, not the active value.
//   0x10  compare B buffer, handled like compare A.
//   0x14  capture register, used as TOP by modes 8, 10, 12 and 14.
//   0x18  status flags, write one to clear; a set in the same cycle wins.
// Any other offset reads as zero and ignores writes.
//
// Bus timing: every access waits exactly one cycle. The request seen at one edge is
// answered by waitrequest low during the next cycle, and readdata stands with it.
// A master that holds its request past that edge starts a second access.
//
// Hazard: a TOP of zero in a dual-slope mode makes the counter wrap downwards, so
// software must load the TOP source before selecting such a mode.

module tcc_timer16 (
  // Clock and reset.
  input  wire logic          core_clk,
  input  wire logic          sys_rst,
  // Timer enable from the prescaler.
  input  wire logic          timer_tick,
  // Register bus.
  input  wire tcc_pkg::tcc_req_type bus_req,
  output      tcc_pkg::tcc_rsp_type bus_rsp,
  // Waveform pins and their override enables.
  output      tcc_pkg::tcc_pin_type pins,
  // Raw status flags for the interrupt controller outside.
  output      logic [2:0]    flags
);
  import tcc_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  tcc_state_type st_r;
  tcc_state_type st_nxt;

  logic [3:0]  wgm;
  tcc_fam_type fam;
  logic [15:0] top;
  logic        at_top;
  logic        at_bottom;
  logic        match_a;
  logic        match_b;
  logic        wr;
  logic        rd;
  logic [1:0]  act_a;
  logic [1:0]  act_b;
  logic        conn_a;
  logic        conn_b;
  logic        frc_a;
  logic        frc_b;
  logic        load_buf;
  logic [2:0]  flag_set;
  logic [2:0]  flag_clr;
  logic        dual_up;
  logic [3:0]  frc_wgm;
  logic        frc_nonpwm;
  logic [1:0]  frc_act_a;
  logic [1:0]  frc_act_b;

  // ----------------------------------------------------------------
  // Mode and bus decode
  // ----------------------------------------------------------------
  // Decode of mode, family and TOP.
  always_comb begin
    wgm = {st_r.mode_hi, st_r.ctrl_a[`TCC_BIT_WGM_HI:`TCC_BIT_WGM_LO]};
    act_a = st_r.ctrl_a[`TCC_BIT_ACT_A_HI:`TCC_BIT_ACT_A_LO];
    act_b = st_r.ctrl_a[`TCC_BIT_ACT_B_HI:`TCC_BIT_ACT_B_LO];
    case (wgm)
      `TCC_MODE_NORMAL, `TCC_MODE_CTC_A, `TCC_MODE_CTC_CAP, 4'hD: fam = TCC_FAM_NONPWM;
      4'h5, 4'h6, 4'h7, `TCC_MODE_FAST_CAP, `TCC_MODE_FAST_A: fam = TCC_FAM_FAST;
      default: fam = TCC_FAM_DUAL;  // Modes 1-3 and 8-11; 8 and 9 are frequency correct.
    endcase
    // TOP source per mode; fixed TOPs serve the 8, 9 and 10 bit modes.
    case (wgm)
      4'h1, 4'h5: top = `TCC_TOP_8;
      4'h2, 4'h6: top = `TCC_TOP_9;
      4'h3, 4'h7: top = `TCC_TOP_10;
      `TCC_MODE_CTC_A, `TCC_MODE_PFC_A, `TCC_MODE_PC_A, `TCC_MODE_FAST_A: top = st_r.cmp_a;
      `TCC_MODE_PFC_CAP, `TCC_MODE_PC_CAP, `TCC_MODE_CTC_CAP, `TCC_MODE_FAST_CAP:
        top = st_r.capture_top;
      default: top = `TCC_TOP_MAX;
    endcase
    // Toggle on 01 is channel A only in modes 15 and 9; B never toggles in PWM.
    conn_a = (act_a != 2'b00) &&
             (fam == TCC_FAM_NONPWM || act_a[1] ||
              (fam == TCC_FAM_FAST && wgm == `TCC_MODE_FAST_A) ||
              (fam == TCC_FAM_DUAL &&
               (wgm == `TCC_MODE_PFC_A || wgm == `TCC_MODE_FAST_CAP)));
    conn_b = (act_b != 2'b00) && (fam == TCC_FAM_NONPWM || act_b[1]);
    at_top    = (st_r.count_value == top);
    at_bottom = (st_r.count_value == 16'h0000);
    match_a   = (st_r.count_value == st_r.cmp_a);
    match_b   = (st_r.count_value == st_r.cmp_b);
    wr = bus_req.write && !st_r.ack;
    rd = bus_req.read && !st_r.ack;
    // Force strobes live for the write cycle only and count only outside PWM modes.
    // The strobe is judged against the actions and low mode bits carried by the same write,
    // so one write can select an action and force it at once.
    frc_wgm = {st_r.mode_hi, bus_req.writedata[`TCC_BIT_WGM_HI:`TCC_BIT_WGM_LO]};
    frc_nonpwm = (frc_wgm == `TCC_MODE_NORMAL) || (frc_wgm == `TCC_MODE_CTC_A) ||
                 (frc_wgm == `TCC_MODE_CTC_CAP) || (frc_wgm == 4'hD);
    frc_act_a = bus_req.writedata[`TCC_BIT_ACT_A_HI:`TCC_BIT_ACT_A_LO];
    frc_act_b = bus_req.writedata[`TCC_BIT_ACT_B_HI:`TCC_BIT_ACT_B_LO];
    frc_a = wr && bus_req.address == `TCC_OFF_CTRL_A &&
            bus_req.writedata[`TCC_BIT_FORCE_A] && frc_nonpwm;
    frc_b = wr && bus_req.address == `TCC_OFF_CTRL_A &&
            bus_req.writedata[`TCC_BIT_FORCE_B] && frc_nonpwm;
    dual_up = !st_r.count_down;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    flag_set = 3'b000;
    flag_clr = 3'b000;
    load_buf = 1'b0;
    st_nxt.ack = 1'b0;

    // Counting, compare matches and their waveform actions happen only in a tick cycle.
    if (timer_tick) begin
      // Compare flags on match; forced compares never touch them.
      flag_set[`TCC_ST_CMPA] = match_a;
      flag_set[`TCC_ST_CMPB] = match_b;
      case (fam)
        TCC_FAM_FAST: begin
          // Single slope: wrap from TOP to BOTTOM and reload the compares there.
          st_nxt.count_value = at_top ? 16'h0000 : st_r.count_value + 16'h0001;
          load_buf = at_top;
          flag_set[`TCC_ST_OVF] = at_top;
          // Match equal TOP with upper bit set is dropped; TOP action only.
          if (at_top && act_a[1]) begin
            st_nxt.wave_a = !act_a[0];
          end else if (match_a) begin
            st_nxt.wave_a = act_a[1] ? act_a[0] : !st_r.wave_a;
          end
          if (at_top && act_b[1]) begin
            st_nxt.wave_b = !act_b[0];
          end else if (match_b && act_b[1]) begin
            st_nxt.wave_b = act_b[0];
          end
        end
        TCC_FAM_DUAL: begin
          // Count up to TOP, turn, count down to BOTTOM, turn again.
          if (st_r.count_down) begin
            st_nxt.count_value = st_r.count_value - 16'h0001;
            if (st_r.count_value == 16'h0001) begin
              st_nxt.count_down = 1'b0;
            end
          end else begin
            st_nxt.count_value = st_r.count_value + 16'h0001;
            if (st_nxt.count_value == top) begin
              st_nxt.count_down = 1'b1;
            end
          end
          // TOP always turns the count round, even after a TOP change mid-slope.
          if (at_top) begin
            st_nxt.count_value = st_r.count_value - 16'h0001;
            st_nxt.count_down = 1'b1;
          end
          // Frequency-correct modes reload at BOTTOM, phase-correct at TOP.
          if (wgm == `TCC_MODE_PFC_CAP || wgm == `TCC_MODE_PFC_A) begin
            load_buf = at_bottom;
          end else begin
            load_buf = at_top;
          end
          flag_set[`TCC_ST_OVF] = at_bottom;
          if (match_a) begin
            if (act_a[1]) begin
              st_nxt.wave_a = dual_up ? act_a[0] : !act_a[0];
            end else begin
              st_nxt.wave_a = !st_r.wave_a;
            end
          end
          if (match_b && act_b[1]) begin
            st_nxt.wave_b = dual_up ? act_b[0] : !act_b[0];
          end
        end
        default: begin
          // Clear-on-match uses A or capture as TOP; normal wraps at MAX.
          st_nxt.count_value = at_top ? 16'h0000 : st_r.count_value + 16'h0001;
          flag_set[`TCC_ST_OVF] = (st_r.count_value == `TCC_TOP_MAX);
          load_buf = 1'b1;
          if (match_a) begin
            st_nxt.wave_a = act_a[1] ? act_a[0] : !st_r.wave_a;
          end
          if (match_b) begin
            st_nxt.wave_b = act_b[1] ? act_b[0] : !st_r.wave_b;
          end
        end
      endcase
    end

    // Forced compare applies the action written with it, without counter or flag effect.
    // It wins over a tick-driven change of the same output in that cycle.
    if (frc_a) begin
      st_nxt.wave_a = frc_act_a[1] ? frc_act_a[0] : !st_r.wave_a;
    end
    if (frc_b) begin
      st_nxt.wave_b = frc_act_b[1] ? frc_act_b[0] : !st_r.wave_b;
    end

    // Non-PWM compare writes land at once; PWM ones wait for the reload point.
    if (load_buf || fam == TCC_FAM_NONPWM) begin
      st_nxt.cmp_a = st_r.cmp_a_buf;
      st_nxt.cmp_b = st_r.cmp_b_buf;
    end

    // Register writes; force bits are never stored.
    // A write to count_value wins over the tick in the same cycle.
    if (wr) begin
      st_nxt.ack = 1'b1;
      case (bus_req.address)
        `TCC_OFF_CTRL_A:  st_nxt.ctrl_a = bus_req.writedata[7:0] & ~`TCC_FORCE_MASK;
        `TCC_OFF_MODE_HI: st_nxt.mode_hi = bus_req.writedata[1:0];
        `TCC_OFF_COUNT:   st_nxt.count_value = bus_req.writedata[15:0];
        `TCC_OFF_CMP_A:   st_nxt.cmp_a_buf = bus_req.writedata[15:0];
        `TCC_OFF_CMP_B:   st_nxt.cmp_b_buf = bus_req.writedata[15:0];
        `TCC_OFF_CAPTURE: st_nxt.capture_top = bus_req.writedata[15:0];
        `TCC_OFF_STATUS:  flag_clr = bus_req.writedata[2:0];
        default: ;
      endcase
    end

    // Reads; unmapped addresses return zero.
    // Compare reads show the buffer, so software sees what it last wrote.
    if (rd) begin
      st_nxt.ack = 1'b1;
      case (bus_req.address)
        `TCC_OFF_CTRL_A:  st_nxt.rdata = {24'h00_0000, st_r.ctrl_a};
        `TCC_OFF_MODE_HI: st_nxt.rdata = {30'h0000_0000, st_r.mode_hi};
        `TCC_OFF_COUNT:   st_nxt.rdata = {16'h0000, st_r.count_value};
        `TCC_OFF_CMP_A:   st_nxt.rdata = {16'h0000, st_r.cmp_a_buf};
        `TCC_OFF_CMP_B:   st_nxt.rdata = {16'h0000, st_r.cmp_b_buf};
        `TCC_OFF_CAPTURE: st_nxt.rdata = {16'h0000, st_r.capture_top};
        `TCC_OFF_STATUS:  st_nxt.rdata = {29'h0000_0000, st_r.status};
        default:          st_nxt.rdata = 32'h0000_0000;
      endcase
    end

    // Write-one-to-clear; a set in the same cycle wins.
    st_nxt.status = (st_r.status & ~flag_clr) | flag_set;

    // Pin override follows the action field; otherwise port control stays.
    st_nxt.pins.wave_out_a = st_nxt.wave_a;
    st_nxt.pins.wave_out_b = st_nxt.wave_b;
    st_nxt.pins.wave_oe_a  = conn_a;
    st_nxt.pins.wave_oe_b  = conn_b;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // All state resets to zero, waveforms low, pins released.
  // The reset is synchronous; one edge with sys_rst high is enough.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Outputs straight from flip-flops; only waitrequest adds an inverter after the ack register.
  always_comb begin
    bus_rsp.readdata    = st_r.rdata;
    bus_rsp.waitrequest = !st_r.ack;
    pins                = st_r.pins;
    flags               = st_r.status;
  end

endmodule // tcc_timer16

//--- shared/tcc_defines.svh
// Register offsets, field positions, reset values and mode codes for the compare-output block.
// Assumes inclusion by bare name from design, bench and checker files.
`ifndef TCC_DEFINES_SVH
`define TCC_DEFINES_SVH
`define TCC_OFF_CTRL_A      5'h00
`define TCC_OFF_MODE_HI     5'h04
`define TCC_OFF_COUNT       5'h08
`define TCC_OFF_CMP_A       5'h0C
`define TCC_OFF_CMP_B       5'h10
`define TCC_OFF_CAPTURE     5'h14
`define TCC_OFF_STATUS      5'h18
`define TCC_CTRL_RESET      8'h00
`define TCC_BIT_ACT_A_HI    7
`define TCC_BIT_ACT_A_LO    6
`define TCC_BIT_ACT_B_HI    5
`define TCC_BIT_ACT_B_LO    4
`define TCC_BIT_FORCE_A     3
`define TCC_BIT_FORCE_B     2
`define TCC_BIT_WGM_HI      1
`define TCC_BIT_WGM_LO      0
`define TCC_FORCE_MASK      8'h0C
`define TCC_ST_OVF          0
`define TCC_ST_CMPA         1
`define TCC_ST_CMPB         2
`define TCC_MODE_NORMAL     4'h0
`define TCC_MODE_CTC_A      4'h4
`define TCC_MODE_PFC_CAP    4'h8
`define TCC_MODE_PFC_A      4'h9
`define TCC_MODE_PC_CAP     4'hA
`define TCC_MODE_PC_A       4'hB
`define TCC_MODE_CTC_CAP    4'hC
`define TCC_MODE_FAST_CAP   4'hE
`define TCC_MODE_FAST_A     4'hF
`define TCC_TOP_8           16'h00FF
`define TCC_TOP_9           16'h01FF
`define TCC_TOP_10          16'h03FF
`define TCC_TOP_MAX         16'hFFFF
`endif

//--- shared/tcc_pkg.sv
// Types shared by the compare-output block.
// Assumes tcc_defines.svh is on the include path.
package tcc_pkg;
  // Avalon-MM request from the master.
  typedef struct packed {
    logic [4:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } tcc_req_type;

  // Avalon-MM answer to the master.
  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } tcc_rsp_type;

  // Pin-facing outputs of one channel pair.
  typedef struct packed {
    logic wave_out_a;
    logic wave_out_b;
    logic wave_oe_a;
    logic wave_oe_b;
  } tcc_pin_type;

  // Mode families.
  typedef enum logic [1:0] {
    TCC_FAM_NONPWM = 2'b00,
    TCC_FAM_FAST   = 2'b01,
    TCC_FAM_DUAL   = 2'b10
  } tcc_fam_type;

  // Whole state of the block.
  typedef struct packed {
    logic [7:0]  ctrl_a;
    logic [1:0]  mode_hi;
    logic [15:0] count_value;
    logic        count_down;
    logic [15:0] cmp_a_buf;
    logic [15:0] cmp_b_buf;
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic [15:0] capture_top;
    logic [2:0]  status;
    logic        wave_a;
    logic        wave_b;
    logic        ack;
    logic [31:0] rdata;
    tcc_pin_type pins;
  } tcc_state_type;
endpackage

//--- tb/tb_top.sv
// Self-checking bench for the compare-output timer block.
// Assumes the checker is bound to the design and the pin model sits on channel A.
`timescale 1ns/10ps
`include "tcc_defines.svh"
module tb_top;
  import tcc_pkg::*;
  logic        core_clk;
  logic        sys_rst;
  logic        timer_tick;
  tcc_req_type bus_req;
  tcc_rsp_type bus_rsp;
  tcc_pin_type pins;
  logic [2:0]  flags;
  logic        pin_a;
  int          fails;
  int          checks_done;
  int          cycles;
  logic [31:0] rd;
  logic [1:0]  frc;
  // ----------------------------------------------------------------
  // Design, pin model, clock and timeout
  // ----------------------------------------------------------------
  tcc_timer16 dut (.core_clk(core_clk), .sys_rst(sys_rst), .timer_tick(timer_tick),
    .bus_req(bus_req), .bus_rsp(bus_rsp), .pins(pins), .flags(flags));
  tcc_port_pin u_pin_a (.wave(pins.wave_out_a), .wave_oe(pins.wave_oe_a), .port_dir(1'b1),
    .port_out(1'b0), .pin(pin_a));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // The whole run needs about 1600 cycles; a hang is cut off well beyond that.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      test_done();
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    check_word({31'h0000_0000, got}, {31'h0000_0000, exp});
  endtask
  // Holds the request until waitrequest is sampled low at a rising edge, takes read
  // data at that edge, then releases and idles one edge.
  task automatic bus_xfer(input logic [4:0] addr, input logic wr, input logic [31:0] wdata);
    bus_req.address <= addr;
    bus_req.write <= wr;
    bus_req.read <= !wr;
    bus_req.writedata <= wdata;
    @(posedge core_clk);
    while (bus_rsp.waitrequest !== 1'b0) @(posedge core_clk);
    rd = bus_rsp.readdata;
    bus_req.read <= 1'b0;
    bus_req.write <= 1'b0;
    @(posedge core_clk);
  endtask
  // One-cycle ticks every other cycle, then a few quiet edges so outputs settle.
  task automatic ticks(input int n);
    repeat (n) begin
      timer_tick <= 1'b1;
      @(posedge core_clk);
      timer_tick <= 1'b0;
      @(posedge core_clk);
    end
    repeat (3) @(posedge core_clk);
  endtask
  task automatic do_reset();
    sys_rst <= 1'b1;
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic test_done();
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    timer_tick = 1'b0;
    bus_req = '0;
    do_reset();
    // Reset value of control A, an unmapped read and quiet flags.
    bus_xfer(`TCC_OFF_CTRL_A, 1'b0, 32'h0000_0000);
    check_word(rd, 32'h0000_0000);
    bus_xfer(5'h01, 1'b0, 32'h0000_0000);
    check_word(rd, 32'h0000_0000);
    check_word({29'h0000_0000, flags}, 32'h0000_0000);
    // Forced set on both channels; force bits read back as zero.
    bus_xfer(`TCC_OFF_CTRL_A, 1'b1, 32'h0000_00FC);
    check_bit(pins.wave_out_a, 1'b1);
    check_bit(pins.wave_out_b, 1'b1);
    check_bit(pin_a, 1'b1);
    check_word({29'h0000_0000, flags}, 32'h0000_0000);
    bus_xfer(`TCC_OFF_CTRL_A, 1'b0, 32'h0000_0000);
    check_word(rd, 32'h0000_00F0);
    $display("test 1 done");
    // Every mode with every action, force bits set only outside PWM modes; the checker
    // judges the overrides and the forced levels.
    for (int m = 0; m < 16; m++) begin
      for (int a = 0; a < 4; a++) begin
        bus_xfer(`TCC_OFF_MODE_HI, 1'b1, {30'h0000_0000, m[3:2]});
        frc = (m inside {0, 4, 12, 13}) ? 2'b11 : 2'b00;
        bus_xfer(`TCC_OFF_CTRL_A, 1'b1, {24'h00_0000, a[1:0], a[1:0], frc, m[1:0]});
      end
    end
    $display("test 2 done");
    // Normal mode: set on match raises only the channel A flag.
    do_reset();
    bus_xfer(`TCC_OFF_CMP_A, 1'b1, 32'h0000_0006);
    bus_xfer(`TCC_OFF_COUNT, 1'b1, 32'h0000_0005);
    bus_xfer(`TCC_OFF_CTRL_A, 1'b1, 32'h0000_00C0);
    ticks(3);
    check_bit(pins.wave_out_a, 1'b1);
    check_word({29'h0000_0000, flags}, 32'h0000_0002);
    $display("test 3 done");
    // Mode 9: toggle once per period, overflow at the bottom.
    do_reset();
    bus_xfer(`TCC_OFF_CMP_A, 1'b1, 32'h0000_0008);
    bus_xfer(`TCC_OFF_MODE_HI, 1'b1, 32'h0000_0002);
    bus_xfer(`TCC_OFF_CTRL_A, 1'b1, 32'h0000_0041);
    ticks(17);
    check_bit(pins.wave_out_a, 1'b1);
    check_bit(flags[0], 1'b1);
    $display("test 4 done");
    // Mode 1, action 10: cleared counting up, set counting down.
    do_reset();
    bus_xfer(`TCC_OFF_CMP_A, 1'b1, 32'h0000_0004);
    bus_xfer(`TCC_OFF_CTRL_A, 1'b1, 32'h0000_00C8);
    check_bit(pins.wave_out_a, 1'b1);
    bus_xfer(`TCC_OFF_CTRL_A, 1'b1, 32'h0000_0081);
    ticks(6);
    check_bit(pins.wave_out_a, 1'b0);
    ticks(502);
    check_bit(pins.wave_out_a, 1'b1);
    $display("test 5 done");
    // Mode 15: toggle each period, match at TOP ignored, force ignored.
    do_reset();
    bus_xfer(`TCC_OFF_CMP_A, 1'b1, 32'h0000_0008);
    bus_xfer(`TCC_OFF_MODE_HI, 1'b1, 32'h0000_0003);
    bus_xfer(`TCC_OFF_CTRL_A, 1'b1, 32'h0000_0043);
    ticks(9);
    check_bit(pins.wave_out_a, 1'b1);
    ticks(9);
    check_bit(pins.wave_out_a, 1'b0);
    bus_xfer(`TCC_OFF_CTRL_A, 1'b1, 32'h0000_00C3);
    ticks(18);
    check_bit(pins.wave_out_a, 1'b0);
    // Force bits written in a PWM mode on purpose, to show that they are ignored.
    bus_xfer(`TCC_OFF_CTRL_A, 1'b1, 32'h0000_00CB);
    check_bit(pins.wave_out_a, 1'b0);
    $display("test 6 done");
    test_done();
  end
endmodule // tb_top

//--- tb/tcc_port_pin.sv
// Port pin model standing behind one waveform output of the timer block.
// Assumes the waveform and its override enable come straight from the block.
`timescale 1ns/10ps
module tcc_port_pin (
  // Waveform side.
  input  wire logic wave,
  input  wire logic wave_oe,
  // Port side, set by software.
  input  wire logic port_dir,
  input  wire logic port_out,
  // Pad.
  output logic      pin
);
  // An input-only pin floats to the pull-up; the override swaps in the waveform.
  assign pin = !port_dir ? 1'b1 : (wave_oe ? wave : port_out);
endmodule // tcc_port_pin

//--- tb/tcc_timer16_chk.sv
// Concurrent checks on the ports of the compare-output timer block.
// Assumes it is bound to every tcc_timer16 and sees only its ports.
`timescale 1ns/10ps
`include "tcc_defines.svh"
module tcc_timer16_chk (
  // Clock and reset.
  input wire logic                 core_clk,
  input wire logic                 sys_rst,
  // Watched ports.
  input wire logic                 timer_tick,
  input wire tcc_pkg::tcc_req_type bus_req,
  input wire tcc_pkg::tcc_rsp_type bus_rsp,
  input wire tcc_pkg::tcc_pin_type pins,
  input wire logic [2:0]           flags
);
  import tcc_pkg::*;
  logic [9:0] shadow_r;
  logic [9:0] shadow_nxt;
  logic       ctrl_ack;
  logic [3:0] mode;
  logic [3:0] wmode;
  // ----------------------------------------------------------------
  // Shadow of control A and upper mode bits
  // ----------------------------------------------------------------
  // Completed writes update the shadow, so it trails the design by one edge.
  assign ctrl_ack = !bus_rsp.waitrequest && bus_req.write && bus_req.address == `TCC_OFF_CTRL_A;
  assign mode = {shadow_r[9:8], shadow_r[1:0]};
  assign wmode = {shadow_r[9:8], bus_req.writedata[1:0]};
  always_comb begin
    shadow_nxt = shadow_r;
    if (ctrl_ack) shadow_nxt[7:0] = bus_req.writedata[7:0];
    if (!bus_rsp.waitrequest && bus_req.write && bus_req.address == `TCC_OFF_MODE_HI)
      shadow_nxt[9:8] = bus_req.writedata[1:0];
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst) shadow_r <= 10'h000;
    else shadow_r <= shadow_nxt;
  end
  // Mode 13 counts as non-PWM, as the block treats it.
  function automatic logic is_pwm(input logic [3:0] m);
    return !(m inside {4'h0, 4'h4, 4'hC, 4'hD});
  endfunction
  function automatic logic oe_exp(input logic [1:0] act, input logic [3:0] m, input logic is_a);
    if (act == 2'b00) return 1'b0;
    if (act[1] || !is_pwm(m)) return 1'b1;
    if (m inside {4'h5, 4'h6, 4'h7, 4'hE, 4'hF}) return is_a && m == 4'hF;
    return is_a && (m == 4'h9 || m == 4'hE);
  endfunction
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence s_quiet;
    !timer_tick && !bus_req.write ##1 !timer_tick && !bus_req.write;
  endsequence
  a_ack_after_req: assert property (
    (bus_req.read || bus_req.write) && bus_rsp.waitrequest |=> !bus_rsp.waitrequest)
    else $error("Access was not answered after one cycle.");
  a_ack_one_cycle: assert property (!bus_rsp.waitrequest |=> bus_rsp.waitrequest)
    else $error("Answer lasted longer than one cycle.");
  a_oe_follows_a: assert property (
    bus_rsp.waitrequest |-> pins.wave_oe_a == oe_exp(shadow_r[7:6], mode, 1'b1))
    else $error("Channel A override does not match action and mode.");
  a_oe_follows_b: assert property (
    bus_rsp.waitrequest |-> pins.wave_oe_b == oe_exp(shadow_r[5:4], mode, 1'b0))
    else $error("Channel B override does not match action and mode.");
  a_force_sets_a: assert property (
    ctrl_ack && bus_req.writedata[3] && bus_req.writedata[7] && !is_pwm(wmode)
    |-> pins.wave_out_a == bus_req.writedata[6]) else $error("Forced compare A not applied.");
  a_force_sets_b: assert property (
    ctrl_ack && bus_req.writedata[2] && bus_req.writedata[5] && !is_pwm(wmode)
    |-> pins.wave_out_b == bus_req.writedata[4]) else $error("Forced compare B not applied.");
  a_force_pwm_ignored: assert property (
    ctrl_ack && bus_req.writedata[3] && is_pwm(wmode) && !$past(timer_tick)
    && !$past(timer_tick, 2) && (bus_req.writedata[7:0] & 8'hF3) == (shadow_r[7:0] & 8'hF3)
    |-> $stable(pins.wave_out_a)) else $error("Forced compare acted in a PWM mode.");
  a_ctrl_readback: assert property (
    !bus_rsp.waitrequest && bus_req.read && bus_req.address == `TCC_OFF_CTRL_A
    |-> bus_rsp.readdata == {24'h00_0000, shadow_r[7:4], 2'b00, shadow_r[1:0]})
    else $error("Control readback wrong.");
  a_reset_quiet: assert property (
    $fell(sys_rst) |-> pins == 4'h0 && flags == 3'b000 && bus_rsp.waitrequest)
    else $error("Outputs not quiet after reset.");
  a_flags_need_tick: assert property (s_quiet |=> $stable(flags))
    else $error("Flags changed without a tick.");
endmodule // tcc_timer16_chk

bind tcc_timer16 tcc_timer16_chk u_chk (.core_clk(core_clk), .sys_rst(sys_rst),
  .timer_tick(timer_tick), .bus_req(bus_req), .bus_rsp(bus_rsp), .pins(pins), .flags(flags));
